// ==== swkcfg_pkg.sv ====
`default_nettype none
package swkcfg_pkg;
  // register indices; byte address is four times the index
  localparam logic [6:0] IDX_DATA_LOW  = 7'h3A;
  localparam logic [6:0] IDX_FD_CFG    = 7'h3B;
  localparam logic [6:0] IDX_OSC_TRIM  = 7'h3C;
  localparam logic [6:0] IDX_OSC_CAL   = 7'h3D;
  localparam logic [6:0] IDX_TRIM_KEY  = 7'h40;
  localparam logic [6:0] IDX_RST_CTRL  = 7'h41;
  localparam int         ADDR_W        = 9;
  // field positions
  localparam int FD_EN_BIT    = 0;
  localparam int FD_FILT_LSB  = 1;
  localparam int FD_ERRDIS_BIT = 5;
  localparam int RXSEL_BIT    = 14;
  localparam int TCOEF_LSB    = 7;
  localparam int TOSC_LSB     = 0;
  // reset values and masks
  localparam logic [15:0] RST_VAL        = 16'h0000;
  localparam logic [15:0] FD_RESTART_KEEP = 16'h002F;
  localparam logic [15:0] FD_RW_MASK     = 16'h002F;
  localparam logic [1:0]  TRIM_UNLOCK    = 2'h3;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  // dominant filter times in ns, and 40 MHz clock period
  localparam int CLK_PERIOD_NS = 25;
  localparam int FILT_STEP_NS  = 50;
  localparam int FILT_MAX_NS   = 775;
  localparam int FILT_MAX_CYC  = FILT_MAX_NS / CLK_PERIOD_NS;
  typedef struct packed {
    logic        enable;
    logic [2:0]  filterCode;
    logic        errCntDisable;
  } swkcf_fd_t;
  typedef struct packed {
    logic        rxSelect;
    logic [4:0]  tempCoef;
    logic [6:0]  oscTrim;
  } swkcf_trim_t;
endpackage : swkcfg_pkg
`default_nettype wire

// ==== swkcf_filter_time.sv ====
`default_nettype none
// maps the 3-bit dominant filter code to a time and a count of clock cycles
module swkcf_filter_time (
  // code in
  input  wire logic [2:0] code,
  // decoded outputs
  output logic      [9:0] timeNs,
  output logic      [5:0] cycles
);
  always_comb begin
    if (code == 3'h7) begin
      timeNs = 10'(swkcfg_pkg::FILT_MAX_NS);
    end else begin
      timeNs = 10'(swkcfg_pkg::FILT_STEP_NS * (int'(code) + 1));
    end
    // count rounds down, never below one cycle
    cycles = 6'(int'(timeNs) / swkcfg_pkg::CLK_PERIOD_NS);
    if (cycles == 6'h00) begin
      cycles = 6'h01;
    end
  end
endmodule // swkcf_filter_time
`default_nettype wire

// ==== swkcf_regs.sv ====
// Summary of operation
// - data register holds byte one high, zero low
// - reserved bits always read as zero
// - bit 0 switches fd tolerant mode
// - filter code selects 50..350 ns, 775 ns
// - bit 5 stops error counter, fd only
// - silence timeout clears error counter disable
// - bit 14 selects low-power or standard receiver
// - trim fields writable only when key is 11
// - calibration status two read-only bytes
// - restart keeps fd bits 5, 3:0
//
// The AXI4-Lite interface to the registers was decided locally.
`default_nettype none
module swkcf_regs (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // AXI4-Lite write address and data
  input  wire logic [8:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [8:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // wake unit side
  input  wire logic              silenceExpired,
  input  wire logic [15:0]       oscCalIn,
  output logic [7:0]             expectedByteZero,
  output logic [7:0]             expectedByteOne,
  output swkcfg_pkg::swkcf_fd_t  fdCfg,
  output swkcfg_pkg::swkcf_trim_t trimCfg,
  output logic                   errCounterRun,
  output logic [5:0]             filterCycles
);
  // ********************
  // state
  // ********************
  typedef struct packed {
    logic        awHeld;
    logic [6:0]  awIdx;
    logic        wHeld;
    logic [15:0] wData;
    logic [1:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [15:0] dataLow;
    swkcfg_pkg::swkcf_fd_t   fd;
    swkcfg_pkg::swkcf_trim_t trim;
    logic [1:0]  trimKey;
    logic [15:0] oscCal;
    logic        errRun;
    logic [5:0]  filtCyc;
    logic        awRdy;
    logic        wRdy;
    logic        arRdy;
  } swkcf_state_t;

  swkcf_state_t s_q;
  swkcf_state_t s_d;

  logic sync1_q;
  logic sync2_q;
  logic [5:0] filtCycComb;
  logic       wrFire;
  logic       softClear;
  logic       restartOnly;

  // write commit and reset-control decode, shared by the checks below
  assign wrFire      = s_q.awHeld && s_q.wHeld && !s_q.bValid;
  assign softClear   = wrFire && (s_q.awIdx == swkcfg_pkg::IDX_RST_CTRL) && s_q.wStrb[0]
                       && s_q.wData[0];
  assign restartOnly = wrFire && (s_q.awIdx == swkcfg_pkg::IDX_RST_CTRL) && s_q.wStrb[0]
                       && !s_q.wData[0] && s_q.wData[1];

  swkcf_filter_time u_filter (
    .code   (s_q.fd.filterCode),
    .timeNs (),
    .cycles (filtCycComb)
  );

  // silence expiry comes from the wake timer domain, synchronise it
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= silenceExpired;
      sync2_q <= sync1_q;
    end
  end

  function automatic logic idxKnown(input logic [6:0] idx);
    idxKnown = idx inside {swkcfg_pkg::IDX_DATA_LOW, swkcfg_pkg::IDX_FD_CFG,
                           swkcfg_pkg::IDX_OSC_TRIM, swkcfg_pkg::IDX_OSC_CAL,
                           swkcfg_pkg::IDX_TRIM_KEY, swkcfg_pkg::IDX_RST_CTRL};
  endfunction

  function automatic logic [15:0] mergeBytes(input logic [15:0] old,
                                             input logic [15:0] nw,
                                             input logic [1:0] strb);
    mergeBytes = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction

  // ********************
  // next state
  // ********************
  always_comb begin
    logic        doWrite;
    logic [15:0] m;
    logic [15:0] fdWord;
    logic [15:0] trimWord;
    logic [15:0] rd;
    doWrite  = 1'b0;
    m        = 16'h0000;
    fdWord   = 16'h0000;
    trimWord = 16'h0000;
    rd       = 16'h0000;
    s_d = s_q;
    s_d.oscCal  = oscCalIn;
    s_d.filtCyc = filtCycComb;
    // counter stops only with fd tolerant mode on
    s_d.errRun  = ~(s_q.fd.errCntDisable & s_q.fd.enable);
    if (awvalid && !s_q.awHeld) begin
      s_d.awHeld = 1'b1;
      s_d.awIdx  = awaddr[8:2];
    end
    if (wvalid && !s_q.wHeld) begin
      s_d.wHeld = 1'b1;
      s_d.wData = wdata[15:0];
      s_d.wStrb = wstrb[1:0];
    end
    if (s_q.bValid && bready) begin
      s_d.bValid = 1'b0;
    end
    if (s_q.awHeld && s_q.wHeld && !s_q.bValid) begin
      doWrite    = 1'b1;
      s_d.awHeld = 1'b0;
      s_d.wHeld  = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp  = idxKnown(s_q.awIdx) ? swkcfg_pkg::RESP_OKAY : swkcfg_pkg::RESP_SLVERR;
    end
    if (doWrite) begin
      m = mergeBytes(16'h0000, s_q.wData, s_q.wStrb);
      case (s_q.awIdx)
        swkcfg_pkg::IDX_DATA_LOW: begin
          s_d.dataLow = mergeBytes(s_q.dataLow, s_q.wData, s_q.wStrb);
        end
        swkcfg_pkg::IDX_FD_CFG: begin
          if (s_q.wStrb[0]) begin
            s_d.fd.enable        = m[swkcfg_pkg::FD_EN_BIT];
            s_d.fd.filterCode    = m[swkcfg_pkg::FD_FILT_LSB +: 3];
            s_d.fd.errCntDisable = m[swkcfg_pkg::FD_ERRDIS_BIT];
          end
        end
        swkcfg_pkg::IDX_OSC_TRIM: begin
          if (s_q.trimKey == swkcfg_pkg::TRIM_UNLOCK) begin
            if (s_q.wStrb[1]) begin
              s_d.trim.rxSelect      = m[swkcfg_pkg::RXSEL_BIT];
              s_d.trim.tempCoef[4:1] = m[11:8];
            end
            if (s_q.wStrb[0]) begin
              s_d.trim.tempCoef[0] = m[swkcfg_pkg::TCOEF_LSB];
              s_d.trim.oscTrim     = m[swkcfg_pkg::TOSC_LSB +: 7];
            end
          end
        end
        swkcfg_pkg::IDX_TRIM_KEY: begin
          if (s_q.wStrb[0]) begin
            s_d.trimKey = m[1:0];
          end
        end
        swkcfg_pkg::IDX_RST_CTRL: begin
          // bit 0 soft reset clears all, bit 1 restart keeps fd bits
          if (s_q.wStrb[0] && m[0]) begin
            s_d.dataLow = swkcfg_pkg::RST_VAL;
            s_d.fd      = '0;
            s_d.trim    = '0;
            s_d.trimKey = 2'h0;
          end else if (s_q.wStrb[0] && m[1]) begin
            s_d.trimKey = 2'h0;
          end
        end
        default: begin
        end
      endcase
    end
    // device clear wins over a simultaneous software write
    if (sync2_q) begin
      s_d.fd.errCntDisable = 1'b0;
    end
    if (s_q.rValid && rready) begin
      s_d.rValid = 1'b0;
    end
    if (arvalid && !s_q.rValid) begin
      fdWord   = {10'h000, s_q.fd.errCntDisable, 1'b0, s_q.fd.filterCode, s_q.fd.enable};
      trimWord = {1'b0, s_q.trim.rxSelect, 2'h0, s_q.trim.tempCoef, s_q.trim.oscTrim};
      case (araddr[8:2])
        swkcfg_pkg::IDX_DATA_LOW: rd = s_q.dataLow;
        swkcfg_pkg::IDX_FD_CFG:   rd = fdWord & swkcfg_pkg::FD_RW_MASK;
        swkcfg_pkg::IDX_OSC_TRIM: rd = trimWord;
        swkcfg_pkg::IDX_OSC_CAL:  rd = s_q.oscCal;
        swkcfg_pkg::IDX_TRIM_KEY: rd = {14'h0000, s_q.trimKey};
        default:                  rd = 16'h0000;
      endcase
      s_d.rValid = 1'b1;
      s_d.rData  = {16'h0000, rd};
      s_d.rResp  = idxKnown(araddr[8:2]) ? swkcfg_pkg::RESP_OKAY : swkcfg_pkg::RESP_SLVERR;
    end
    // readies kept as flops of their own, so no output passes a gate
    s_d.awRdy = ~s_d.awHeld;
    s_d.wRdy  = ~s_d.wHeld;
    s_d.arRdy = ~s_d.rValid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.errRun  <= 1'b1;
      s_q.filtCyc <= 6'h02;
      s_q.awRdy   <= 1'b1;
      s_q.wRdy    <= 1'b1;
      s_q.arRdy   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ********************
  // outputs
  // ********************
  // ready only while the holding slot is empty, so never combinational on valid
  assign awready          = s_q.awRdy;
  assign wready           = s_q.wRdy;
  assign bvalid           = s_q.bValid;
  assign bresp            = s_q.bResp;
  assign arready          = s_q.arRdy;
  assign rvalid           = s_q.rValid;
  assign rdata            = s_q.rData;
  assign rresp            = s_q.rResp;
  assign expectedByteZero = s_q.dataLow[7:0];
  assign expectedByteOne  = s_q.dataLow[15:8];
  assign fdCfg            = s_q.fd;
  assign trimCfg          = s_q.trim;
  assign errCounterRun    = s_q.errRun;
  assign filterCycles     = s_q.filtCyc;

  // ********************
  // checks
  // ********************
  // soft reset may clear trim with the key shut; that is not a locked write
  AST_TRIM_LOCK: assert property (@(posedge clk) disable iff (rst)
    (s_q.trimKey != swkcfg_pkg::TRIM_UNLOCK && !softClear) |=> $stable(s_q.trim) || $past(rst))
    else $error("trim changed while locked");
  AST_TRIM_KEEP: assert property (@(posedge clk) disable iff (rst)
    (wrFire && s_q.awIdx == swkcfg_pkg::IDX_OSC_TRIM && s_q.trimKey != swkcfg_pkg::TRIM_UNLOCK)
    |=> $stable(s_q.trim))
    else $error("locked trim write took effect");
  AST_RXSEL_WR: assert property (@(posedge clk) disable iff (rst)
    (wrFire && s_q.awIdx == swkcfg_pkg::IDX_OSC_TRIM && s_q.trimKey == swkcfg_pkg::TRIM_UNLOCK
     && s_q.wStrb[1]) |=> trimCfg.rxSelect == $past(s_q.wData[swkcfg_pkg::RXSEL_BIT]))
    else $error("receiver select not written");
  AST_SILENCE_CLR: assert property (@(posedge clk) disable iff (rst)
    sync2_q |=> !s_q.fd.errCntDisable)
    else $error("error counter disable not cleared");
  AST_ERR_RUN: assert property (@(posedge clk) disable iff (rst)
    (s_q.fd.errCntDisable && s_q.fd.enable) |=> !errCounterRun)
    else $error("error counter not stopped");
  AST_ERR_NOFD: assert property (@(posedge clk) disable iff (rst)
    !s_q.fd.enable |=> errCounterRun)
    else $error("error counter stopped without fd mode");
  AST_FD_WR: assert property (@(posedge clk) disable iff (rst)
    (wrFire && s_q.awIdx == swkcfg_pkg::IDX_FD_CFG && s_q.wStrb[0])
    |=> fdCfg.enable == $past(s_q.wData[swkcfg_pkg::FD_EN_BIT])
    && fdCfg.filterCode == $past(s_q.wData[swkcfg_pkg::FD_FILT_LSB +: 3]))
    else $error("fd enable or filter code not written");
  // a silence clear in the same cycle overrides the written bit
  AST_ERRDIS_WR: assert property (@(posedge clk) disable iff (rst)
    (wrFire && s_q.awIdx == swkcfg_pkg::IDX_FD_CFG && s_q.wStrb[0] && !sync2_q)
    |=> fdCfg.errCntDisable == $past(s_q.wData[swkcfg_pkg::FD_ERRDIS_BIT]))
    else $error("error counter disable not written");
  AST_FD_RSVD: assert property (@(posedge clk) disable iff (rst)
    (arvalid && arready && araddr[8:2] == swkcfg_pkg::IDX_FD_CFG)
    |=> rdata[31:6] == '0 && !rdata[4])
    else $error("fd reserved bits nonzero");
  AST_TRIM_RSVD: assert property (@(posedge clk) disable iff (rst)
    (arvalid && arready && araddr[8:2] == swkcfg_pkg::IDX_OSC_TRIM)
    |=> rdata[15] == 1'b0 && rdata[13:12] == 2'h0)
    else $error("trim reserved bits nonzero");
  AST_RD_UNMAPPED: assert property (@(posedge clk) disable iff (rst)
    (arvalid && arready && !idxKnown(araddr[8:2]))
    |=> rdata == 32'h00000000 && rresp == swkcfg_pkg::RESP_SLVERR)
    else $error("unmapped read not refused with zero data");
  AST_RDATA_HIGH: assert property (@(posedge clk) disable iff (rst)
    rvalid |-> rdata[31:16] == 16'h0000)
    else $error("read data upper half nonzero");
  AST_FILT_MAX: assert property (@(posedge clk) disable iff (rst)
    (s_q.fd.filterCode == 3'h7) |=> filterCycles == 6'(swkcfg_pkg::FILT_MAX_CYC))
    else $error("filter time wrong for code 7");
  AST_FILT_CODE: assert property (@(posedge clk) disable iff (rst)
    (s_q.fd.filterCode != 3'h7) |=> filterCycles == 6'((int'($past(s_q.fd.filterCode)) + 1)
    * swkcfg_pkg::FILT_STEP_NS / swkcfg_pkg::CLK_PERIOD_NS))
    else $error("filter time wrong for stepped code");
  AST_DATA_WR: assert property (@(posedge clk) disable iff (rst)
    (s_q.awHeld && s_q.wHeld && !s_q.bValid && s_q.awIdx == swkcfg_pkg::IDX_DATA_LOW
     && s_q.wStrb == 2'h3) |=> expectedByteZero == $past(s_q.wData[7:0])
     && expectedByteOne == $past(s_q.wData[15:8]))
    else $error("data bytes not stored");
  AST_DATA_RD: assert property (@(posedge clk) disable iff (rst)
    (arvalid && arready && araddr[8:2] == swkcfg_pkg::IDX_DATA_LOW)
    |=> rdata == {16'h0000, $past(s_q.dataLow)})
    else $error("data register read wrong");
  AST_CAL_RD: assert property (@(posedge clk) disable iff (rst)
    (arvalid && arready && araddr[8:2] == swkcfg_pkg::IDX_OSC_CAL)
    |=> rdata[15:0] == $past(s_q.oscCal))
    else $error("calibration read wrong");
  AST_SOFT_CLR: assert property (@(posedge clk) disable iff (rst)
    softClear |=> s_q.fd == '0 && s_q.dataLow == 16'h0000 && s_q.trim == '0
    && s_q.trimKey == 2'h0)
    else $error("soft reset left state behind");
  // restart must not disturb the fd settings, only shut the trim key
  AST_RESTART_KEEP: assert property (@(posedge clk) disable iff (rst)
    restartOnly |=> fdCfg.enable == $past(s_q.fd.enable)
    && fdCfg.filterCode == $past(s_q.fd.filterCode) && s_q.trimKey == 2'h0)
    else $error("restart changed fd settings");
  COV_WRITE: cover property (@(posedge clk) bvalid && bready);
  COV_READ: cover property (@(posedge clk) rvalid && rready);
  COV_TRIM_WR: cover property (@(posedge clk) s_q.trimKey == swkcfg_pkg::TRIM_UNLOCK
    && $changed(s_q.trim));
  COV_SILENCE: cover property (@(posedge clk) sync2_q && s_q.fd.errCntDisable);
  COV_RESTART: cover property (@(posedge clk) restartOnly);
endmodule // swkcf_regs
`default_nettype wire

// ==== swkcf_wake_model.sv ====
`default_nettype none
module swkcf_wake_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // bench requests
  input  wire logic        fireSilence,
  input  wire logic [15:0] calWord,
  // toward the register bank
  output logic             silenceExpired,
  output logic      [15:0] oscCalIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] holdCnt_q;
  // frames not modelled, length codes taken as matching
  // ****************************
  // silence timeout pulse
  // ****************************
  // three cycles wide, above the one-cycle minimum the bank needs
  always_ff @(posedge clk) begin
    if (rst) begin
      holdCnt_q <= 2'h0;
    end else if (fireSilence) begin
      holdCnt_q <= 2'h3;
    end else if (holdCnt_q != 2'h0) begin
      holdCnt_q <= holdCnt_q - 2'h1;
    end
  end
  assign silenceExpired = (holdCnt_q != 2'h0);
  always_ff @(posedge clk) begin
    oscCalIn <= calWord;
  end
endmodule // swkcf_wake_model
`default_nettype wire

// ==== selective_wake_cfg_regs_tb.sv ====
`default_nettype none
module selective_wake_cfg_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DAT = swkcfg_pkg::IDX_DATA_LOW;
  localparam logic [6:0] FDC = swkcfg_pkg::IDX_FD_CFG;
  localparam logic [6:0] TRM = swkcfg_pkg::IDX_OSC_TRIM;
  localparam logic [6:0] CAL = swkcfg_pkg::IDX_OSC_CAL;
  localparam logic [6:0] KEY = swkcfg_pkg::IDX_TRIM_KEY;
  localparam logic [6:0] RSC = swkcfg_pkg::IDX_RST_CTRL;
  logic clk = 1'b0, rst = 1'b1;
  logic [8:0] awaddr = 9'h000, araddr = 9'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, silenceExpired, errCounterRun;
  logic [1:0] bresp, rresp;
  logic fireSilence = 1'b0;
  logic [15:0] calWord, oscCalIn, d;
  logic [7:0] byteZero, byteOne;
  logic [5:0] filterCycles;
  swkcfg_pkg::swkcf_fd_t fdCfg;
  swkcfg_pkg::swkcf_trim_t trimCfg;
  logic [33:0] rdQ[$], e;
  logic [1:0] wrQ[$];
  int n_mismatch = 0, checks = 0;
  always #12.5 clk = ~clk;
  swkcf_regs i_dut (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .silenceExpired(silenceExpired), .oscCalIn(oscCalIn), .expectedByteZero(byteZero),
    .expectedByteOne(byteOne), .fdCfg(fdCfg), .trimCfg(trimCfg),
    .errCounterRun(errCounterRun), .filterCycles(filterCycles));
  swkcf_wake_model i_wake (.clk(clk), .rst(rst), .fireSilence(fireSilence),
    .calWord(calWord), .silenceExpired(silenceExpired), .oscCalIn(oscCalIn));
  // ****************************
  // compare and bus tasks
  // ****************************
  task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  function automatic logic [1:0] respOf(input logic [6:0] i);
    return (i inside {DAT, FDC, TRM, CAL, KEY, RSC}) ? swkcfg_pkg::RESP_OKAY
                                                     : swkcfg_pkg::RESP_SLVERR;
  endfunction
  task automatic wr(input logic [6:0] i, input logic [15:0] v, input logic [3:0] s = 4'h3);
    wrQ.push_back(respOf(i));
    awaddr <= {i, 2'b00};
    awvalid <= 1'b1;
    wdata <= {16'h0, v};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    // bready stays up between writes, so it never toggles in one step
    do @(posedge clk); while (bvalid !== 1'b1);
  endtask
  // unmapped places read back zero data
  task automatic rd(input logic [6:0] i, input logic [15:0] v);
    rdQ.push_back({respOf(i), 16'h0, (respOf(i) == swkcfg_pkg::RESP_OKAY) ? v : 16'h0});
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
  endtask
  always @(posedge clk) begin
    if (bvalid && bready) begin
      cmp("bresp", {30'h0, wrQ.pop_front()}, {30'h0, bresp});
    end
    if (rvalid && rready) begin
      e = rdQ.pop_front();
      cmp("rdata", e[31:0], rdata);
      cmp("rresp", {30'h0, e[33:32]}, {30'h0, rresp});
    end
  end
  task automatic end_of_test;
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
  // ****************************
  // scenarios
  // ****************************
  initial begin
    void'($urandom(4451));
    calWord = 16'($urandom);
    d = 16'($urandom);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(DAT, 16'h0);
    rd(FDC, 16'h0);
    rd(TRM, 16'h0);
    rd(CAL, calWord);
    cmp("errRun", 32'h1, {31'h0, errCounterRun});
    wr(DAT, d);
    wr(DAT, ~d, 4'h2);
    rd(DAT, {~d[15:8], d[7:0]});
    cmp("byteZero", {24'h0, d[7:0]}, {24'h0, byteZero});
    cmp("byteOne", {24'h0, ~d[15:8]}, {24'h0, byteOne});
    for (int c = 0; c < 8; c++) begin
      wr(FDC, 16'hFFD1 | 16'(c << 1));
      rd(FDC, 16'h0001 | 16'(c << 1));
      cmp("filter", (c == 7) ? 32'd31 : 32'(2 * (c + 1)), {26'h0, filterCycles});
      cmp("fdCfg", {27'h0, 1'b1, 3'(c), 1'b0}, {27'h0, fdCfg});
    end
    wr(FDC, 16'h0020);
    @(posedge clk);
    cmp("errRun", 32'h1, {31'h0, errCounterRun});
    wr(FDC, 16'h0021);
    @(posedge clk);
    cmp("errRun", 32'h0, {31'h0, errCounterRun});
    fireSilence <= 1'b1;
    @(posedge clk);
    fireSilence <= 1'b0;
    repeat (5) @(posedge clk);
    rd(FDC, 16'h0001);
    cmp("errRun", 32'h1, {31'h0, errCounterRun});
    // trim stays locked until the key reads 3; coarse trim is left alone
    for (int k = 0; k < 4; k++) begin
      wr(KEY, 16'(k));
      wr(TRM, 16'hFF80);
      rd(TRM, (k == 3) ? 16'h4F80 : 16'h0);
    end
    cmp("rxSel", 32'h1, {31'h0, trimCfg.rxSelect});
    cmp("trimCfg", 32'h00001F80, {19'h0, trimCfg});
    wr(CAL, ~calWord);
    rd(CAL, calWord);
    wr(7'h10, d);
    rd(7'h10, 16'h0);
    wr(FDC, 16'h002F);
    wr(RSC, 16'h0002);
    rd(FDC, 16'h002F);
    rd(DAT, {~d[15:8], d[7:0]});
    wr(TRM, 16'h0000);
    rd(TRM, 16'h4F80);
    wr(RSC, 16'h0001);
    rd(FDC, 16'h0);
    rd(DAT, 16'h0);
    rd(TRM, 16'h0);
    @(posedge clk);
    end_of_test;
  end
endmodule // selective_wake_cfg_regs_tb
`default_nettype wire
